//--- pmi_mii_port.sv
`timescale 1ns/1ps
`default_nettype none

module pmi_mii_port
   import pmi_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Link configuration from forced setting or negotiation.
   input wire logic i_speed_100,
   input wire logic i_full_duplex,
   input wire logic i_heartbeat_en,
   // MAC transmit side.
   output logic o_tx_clk,
   input wire logic [NIB_W-1:0] i_txd,
   input wire logic i_tx_en,
   input wire logic i_tx_er,
   output logic o_tx_overrun,
   // MAC receive side.
   output logic o_rx_clk,
   output logic [NIB_W-1:0] o_rxd,
   output logic o_rx_dv,
   output logic o_rx_er,
   output logic o_crs,
   output logic o_col,
   // Line transmit pair encoder.
   output logic o_line_tx_valid,
   input wire logic i_line_tx_ready,
   output logic [NIB_W-1:0] o_line_tx_nibble,
   output logic o_line_tx_halt,
   output logic o_line_tx_active,
   output logic o_line_speed_100,
   // Line receive decoder.
   input wire logic i_line_rx_carrier,
   input wire logic i_line_rx_valid,
   input wire logic [NIB_W-1:0] i_line_rx_nibble,
   input wire logic i_line_rx_code_err,
   // Management pins and the frame engine behind them.
   input wire logic i_mdc,
   input wire logic i_mdio_in,
   output logic o_mdio_out,
   output logic o_mdio_oe,
   input wire logic i_mgmt_drive,
   input wire logic i_mgmt_bit,
   output logic o_mgmt_sample,
   output logic o_mgmt_bit
);

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_meta_r;
   logic rst_n_r;

   // Assertion is immediate; release waits two edges to avoid a runt.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   // ----------------------------------------
   // MII clock generation
   // ----------------------------------------
   logic [DIV_W-1:0] div_cnt_r;
   logic mii_clk_r;
   logic mii_rise;
   logic mii_fall;
   logic div_wrap;

   function automatic logic [DIV_W-1:0] half_cycles(input logic spd100);
      half_cycles = spd100 ? HALF_100_CYC : HALF_10_CYC;
   endfunction

   // At 40 MHz the 25 MHz rate is not reachable; the 100 Mb/s half
   // period clamps to one cycle, so the real part runs this from the
   // 25 MHz reference instead.
   assign div_wrap = (div_cnt_r >= half_cycles(i_speed_100) - 1'b1);
   assign mii_rise = div_wrap & ~mii_clk_r;
   assign mii_fall = div_wrap & mii_clk_r;

   // One divider drives both clocks; the wrap compare uses the current speed, so a change applies at the next cycle.
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         div_cnt_r <= '0;
         mii_clk_r <= 1'b0;
      end else if (div_wrap) begin
         div_cnt_r <= '0;
         mii_clk_r <= ~mii_clk_r;
      end else begin
         div_cnt_r <= div_cnt_r + 1'b1;
      end
   end

   // Clock outputs come from flops that mirror the divider phase.
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_tx_clk <= 1'b0;
         o_rx_clk <= 1'b0;
      end else begin
         o_tx_clk <= mii_clk_r ^ div_wrap;
         o_rx_clk <= mii_clk_r ^ div_wrap;
      end
   end

   // ----------------------------------------
   // Transmit sampling
   // ----------------------------------------
   logic tx_act_r;
   logic tx_push;
   logic tx_halt;
   logic buf_in_ready;
   logic buf_out_valid;
   logic [TXB_W-1:0] buf_out_data;

   // Inputs are taken at the rising transmit clock edge only.
   assign tx_push = mii_rise & i_tx_en;
   // Error only matters at 100 Mb/s and only alongside enable.
   assign tx_halt = i_speed_100 & i_tx_er;

   // Transmit activity follows enable as seen at each rising edge.
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         tx_act_r <= 1'b0;
      end else if (mii_rise) begin
         tx_act_r <= i_tx_en;
      end
   end

   // The MAC cannot be stalled, so a nibble refused is flagged, not lost silently.
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_tx_overrun <= 1'b0;
      end else if (tx_push && !buf_in_ready) begin
         o_tx_overrun <= 1'b1;
      end else if (mii_rise && !i_tx_en) begin
         o_tx_overrun <= 1'b0;
      end
   end

   pmi_skid_buf #(
      .WIDTH(TXB_W),
      .DEPTH(BUF_DEPTH)
   ) u_tx_buf (
      .i_clk(i_clk),
      .i_rst_n(rst_n_r),
      .i_valid(tx_push),
      .o_ready(buf_in_ready),
      .i_data({tx_halt, i_txd}),
      .o_valid(buf_out_valid),
      .i_ready(!o_line_tx_valid || i_line_tx_ready),
      .o_data(buf_out_data)
   );

   // Output stage holds a word until the encoder takes it.
   // Valid never waits on ready, so a stalled encoder still gains a third slot.
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_line_tx_valid <= 1'b0;
         o_line_tx_nibble <= NIB_ZERO;
         o_line_tx_halt <= 1'b0;
      end else if (!o_line_tx_valid || i_line_tx_ready) begin
         o_line_tx_valid <= buf_out_valid;
         o_line_tx_nibble <= buf_out_data[NIB_W-1:0];
         o_line_tx_halt <= buf_out_data[TXB_HALT_BIT];
      end
   end

   // Line configuration follows the resolved speed.
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_line_speed_100 <= 1'b0;
         o_line_tx_active <= 1'b0;
      end else begin
         o_line_speed_100 <= i_speed_100;
         o_line_tx_active <= tx_act_r;
      end
   end

   // ----------------------------------------
   // Receive presentation
   // ----------------------------------------
   logic rx_hold_r;
   logic [NIB_W-1:0] rx_nib_r;
   logic rx_err_r;

   // A decoded nibble waits here until the next falling edge.
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rx_hold_r <= 1'b0;
         rx_nib_r <= NIB_ZERO;
         rx_err_r <= 1'b0;
      end else if (i_line_rx_valid) begin
         rx_hold_r <= 1'b1;
         rx_nib_r <= i_line_rx_nibble;
         rx_err_r <= i_line_rx_code_err & i_speed_100;
      end else if (mii_fall) begin
         rx_hold_r <= 1'b0;
      end
   end

   // Data, valid and error all change only at the falling edge.
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_rxd <= NIB_ZERO;
         o_rx_dv <= 1'b0;
         o_rx_er <= 1'b0;
      end else if (mii_fall) begin
         o_rxd <= rx_hold_r ? rx_nib_r : NIB_ZERO;
         o_rx_dv <= rx_hold_r;
         o_rx_er <= rx_hold_r & rx_err_r;
      end
   end

   // ----------------------------------------
   // Carrier, collision and heartbeat
   // ----------------------------------------
   logic [SQE_W-1:0] sqe_cnt_r;
   logic tx_act_d_r;
   logic sqe_start;

   assign sqe_start = tx_act_d_r & ~tx_act_r & ~i_speed_100 &
                      ~i_full_duplex & i_heartbeat_en;

   // Heartbeat counts out about one microsecond after transmit ends.
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         tx_act_d_r <= 1'b0;
         sqe_cnt_r <= '0;
      end else begin
         tx_act_d_r <= tx_act_r;
         if (i_full_duplex) begin
            sqe_cnt_r <= '0;
         end else if (sqe_start) begin
            sqe_cnt_r <= SQE_CYC;
         end else if (sqe_cnt_r != '0) begin
            sqe_cnt_r <= sqe_cnt_r - 1'b1;
         end
      end
   end

   // Duplex decides whether our own transmit counts as carrier.
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_crs <= 1'b0;
         o_col <= 1'b0;
      end else if (i_full_duplex) begin
         o_crs <= i_line_rx_carrier;
         o_col <= 1'b0;
      end else begin
         o_crs <= i_line_rx_carrier | tx_act_r;
         o_col <= (i_line_rx_carrier & tx_act_r) | (sqe_cnt_r != '0);
      end
   end

   // ----------------------------------------
   // Management pins
   // ----------------------------------------
   logic mdc_d_r;

   // Management clock is sampled as a plain input; its rate limit is
   // the agent's job, and at 40 MHz only slower clocks are seen cleanly.
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mdc_d_r <= 1'b0;
         o_mgmt_sample <= 1'b0;
         o_mgmt_bit <= 1'b0;
      end else begin
         mdc_d_r <= i_mdc;
         o_mgmt_sample <= i_mdc & ~mdc_d_r;
         if (i_mdc && !mdc_d_r) begin
            o_mgmt_bit <= i_mdio_in;
         end
      end
   end

   // Open drain: only ever pull low; the pull-up supplies the ones.
   always_ff @(posedge i_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         o_mdio_out <= 1'b0;
         o_mdio_oe <= 1'b0;
      end else begin
         o_mdio_out <= 1'b0;
         o_mdio_oe <= i_mgmt_drive & ~i_mgmt_bit;
      end
   end

endmodule

`default_nettype wire

//--- pmi_pkg.sv
// How it works
// - Management data pin is open drain; either end may pull it low.
// - Half duplex: carrier sense high for receive or transmit activity.
// - Full duplex: carrier sense follows receive activity only.
// - Half duplex: collision high while transmit and receive overlap.
// - 10 Mb/s half duplex with heartbeat: collision pulse about 1 us after transmit.
// - Full duplex: collision always low, no heartbeat.
// - Transmit clock is 25 MHz at 100 Mb/s, 2.5 MHz at 10 Mb/s; here it is 20 MHz at 100 Mb/s.
// - At 100 Mb/s, transmit error with enable sends the halt code.
// - At 10 Mb/s the transmit error input is ignored.
// - Receive clock is 25 MHz at 100 Mb/s, 2.5 MHz at 10 Mb/s; here it is 20 MHz at 100 Mb/s.
// - Receive data changes only at the falling edge of the receive clock.
// - Receive valid is high with valid nibbles, changed at the falling edge.
// - At 100 Mb/s, receive error marks an invalid code group in a packet.
// - Line paths follow the speed from forced setting or negotiation.
`default_nettype none
package pmi_pkg;

   // ----------------------------------------
   // Clocking
   // ----------------------------------------
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned MII_CLK_100_HZ = 25_000_000;
   localparam int unsigned MII_CLK_10_HZ = 2_500_000;
   localparam int unsigned MDC_MAX_HZ = 25_000_000;
   localparam int DIV_W = 8;
   // Half periods round down but never below one cycle.
   localparam int unsigned HALF_100_RAW = CLK_HZ / (2 * MII_CLK_100_HZ);
   localparam int unsigned HALF_10_RAW = CLK_HZ / (2 * MII_CLK_10_HZ);
   localparam logic [DIV_W-1:0] HALF_100_CYC =
      DIV_W'((HALF_100_RAW < 1) ? 1 : HALF_100_RAW);
   localparam logic [DIV_W-1:0] HALF_10_CYC =
      DIV_W'((HALF_10_RAW < 1) ? 1 : HALF_10_RAW);

   // ----------------------------------------
   // Heartbeat
   // ----------------------------------------
   localparam int unsigned SQE_NS = 1000;
   localparam int SQE_W = 8;
   localparam logic [SQE_W-1:0] SQE_CYC =
      SQE_W'((SQE_NS * (CLK_HZ / 1_000_000)) / 1000);

   // ----------------------------------------
   // Data path
   // ----------------------------------------
   localparam int NIB_W = 4;
   localparam int TXB_W = NIB_W + 1;
   localparam int TXB_HALT_BIT = NIB_W;
   localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
   localparam int BUF_DEPTH = 2;

endpackage

`default_nettype wire

//--- pmi_skid_buf.sv
`timescale 1ns/1ps
`default_nettype none

module pmi_skid_buf
   import pmi_pkg::*;
#(
   parameter int WIDTH = TXB_W,
   parameter int DEPTH = BUF_DEPTH
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_valid,
   input wire logic i_ready,
   output logic [WIDTH-1:0] o_data
);

   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
   localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PTR_W-1:0] wr_ptr_r;
   logic [PTR_W-1:0] rd_ptr_r;
   logic [CNT_W-1:0] cnt_r;
   logic push;
   logic pop;

   // Full and empty come straight from the count, so both stay honest.
   assign o_ready = (cnt_r != FULL_CNT);
   assign o_valid = (cnt_r != '0);
   assign o_data = mem_r[rd_ptr_r];
   assign push = i_valid & o_ready;
   assign pop = o_valid & i_ready;

   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
      ptr_inc = (p == LAST_PTR) ? '0 : p + 1'b1;
   endfunction

   // Storage needs no reset; valid data is qualified by the count.
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= i_data;
      end
   end

   // Pointers and occupancy.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= ptr_inc(wr_ptr_r);
         end
         if (pop) begin
            rd_ptr_r <= ptr_inc(rd_ptr_r);
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

//--- pmi_mii_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// MII port protocol checker
// ------------------------------
module pmi_mii_port_sva
   import pmi_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_speed_100,
   input wire logic i_full_duplex,
   input wire logic i_heartbeat_en,
   input wire logic o_tx_clk,
   input wire logic o_rx_clk,
   input wire logic [NIB_W-1:0] o_rxd,
   input wire logic o_rx_dv,
   input wire logic o_crs,
   input wire logic o_col,
   input wire logic o_line_tx_active,
   input wire logic i_line_rx_carrier,
   input wire logic o_mdio_out,
   input wire logic o_mdio_oe,
   input wire logic i_mgmt_drive,
   input wire logic i_mgmt_bit
);
   logic [2:0] up_r;
   // Outputs stay low two edges after reset, so relations wait for this.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         up_r <= 3'h0;
      end else begin
         up_r <= {up_r[1:0], 1'b1};
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // The activity output lags the internal flag by one edge, so it is compared unshifted.
   a_crs_half: assert property (up_r[2] && !i_full_duplex && $past(!i_full_duplex)
      |-> o_crs == ($past(i_line_rx_carrier) || o_line_tx_active)) else $error("crs half");
   a_crs_full: assert property (up_r[2] && i_full_duplex && $past(i_full_duplex)
      |-> o_crs == $past(i_line_rx_carrier)) else $error("crs full");
   a_col_full: assert property (up_r[2] && i_full_duplex && $past(i_full_duplex)
      |-> !o_col) else $error("col in full duplex");
   a_col_overlap: assert property (up_r[2] && !i_full_duplex && $past(!i_full_duplex)
      && $past(i_line_rx_carrier) && o_line_tx_active |-> o_col) else $error("col missing");
   a_sqe_pulse: assert property (!i_speed_100 && !i_full_duplex && i_heartbeat_en
      && $fell(o_line_tx_active) |-> ##2 o_col [*8] ##30 o_col ##[1:4] !o_col)
      else $error("heartbeat length");
   a_rx_edge: assert property (up_r[2] && !$stable({o_rxd, o_rx_dv})
      |-> $fell(o_rx_clk)) else $error("rx change off fall");
   a_clk_pair: assert property (o_rx_clk == o_tx_clk) else $error("rx clk phase");
   a_tx_clk_slow: assert property ($rose(o_tx_clk) && !i_speed_100
      |-> (o_tx_clk [*8] ##1 !o_tx_clk) or (##[0:8] i_speed_100)) else $error("tx clk");
   a_mdio_pull: assert property (up_r[2] |-> !o_mdio_out
      && o_mdio_oe == $past(i_mgmt_drive && !i_mgmt_bit)) else $error("mdio pull");
endmodule
bind pmi_mii_port pmi_mii_port_sva i_pmi_mii_port_sva (
   .i_clk(i_clk),
   .i_rst_n(i_rst_n),
   .i_speed_100(i_speed_100),
   .i_full_duplex(i_full_duplex),
   .i_heartbeat_en(i_heartbeat_en),
   .o_tx_clk(o_tx_clk),
   .o_rx_clk(o_rx_clk),
   .o_rxd(o_rxd),
   .o_rx_dv(o_rx_dv),
   .o_crs(o_crs),
   .o_col(o_col),
   .o_line_tx_active(o_line_tx_active),
   .i_line_rx_carrier(i_line_rx_carrier),
   .o_mdio_out(o_mdio_out),
   .o_mdio_oe(o_mdio_oe),
   .i_mgmt_drive(i_mgmt_drive),
   .i_mgmt_bit(i_mgmt_bit)
);
`default_nettype wire

//--- pmi_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// MAC and line encoder stand-in
// ------------------------------
module pmi_mac_model
   import pmi_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_tx_clk,
   input wire logic i_stall,
   input wire logic i_line_tx_valid,
   input wire logic [NIB_W-1:0] i_line_tx_nibble,
   input wire logic i_line_tx_halt,
   output logic o_line_tx_ready,
   output logic [NIB_W-1:0] o_txd,
   output logic o_tx_en,
   output logic o_tx_er
);
   logic [TXB_W-1:0] got[$];
   // The encoder takes a nibble whenever the bench is not stalling it.
   assign o_line_tx_ready = !i_stall;
   // Accepted nibbles are kept with their halt flag for the bench.
   always @(posedge i_clk) begin
      if (i_line_tx_valid && o_line_tx_ready) begin
         got.push_back({i_line_tx_halt, i_line_tx_nibble});
      end
   end
   initial begin
      {o_txd, o_tx_en, o_tx_er} = 6'h0;
   end
   // Change just after a rise so the next rise samples a settled nibble.
   // Idle data toggles, so a port that takes it while disabled is caught.
   task automatic send(input logic en, input logic [NIB_W-1:0] n, input logic er);
      @(posedge i_tx_clk);
      @(posedge i_clk);
      o_tx_en <= en;
      o_txd <= en ? n : ~o_txd;
      o_tx_er <= er;
   endtask
endmodule
`default_nettype wire

//--- pmi_mii_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// MII port bench
// ------------------------------
module pmi_mii_port_tb_top
   import pmi_pkg::*;
;
   logic i_clk, i_rst_n, i_speed_100, i_full_duplex, i_heartbeat_en, stall, sme_pull;
   logic [NIB_W-1:0] i_txd, o_rxd, o_line_tx_nibble, i_line_rx_nibble;
   logic i_tx_en, i_tx_er, o_tx_clk, o_tx_overrun, o_rx_clk, o_rx_dv, o_rx_er;
   logic o_crs, o_col, o_line_tx_valid, i_line_tx_ready, o_line_tx_halt;
   logic o_line_tx_active, o_line_speed_100, i_line_rx_carrier, i_line_rx_valid;
   logic i_line_rx_code_err, i_mdc, i_mdio_in, o_mdio_out, o_mdio_oe;
   logic i_mgmt_drive, i_mgmt_bit, o_mgmt_sample, o_mgmt_bit;
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;
   pmi_mii_port i_pmi_mii_port (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_speed_100(i_speed_100),
      .i_full_duplex(i_full_duplex), .i_heartbeat_en(i_heartbeat_en), .o_tx_clk(o_tx_clk),
      .i_txd(i_txd), .i_tx_en(i_tx_en), .i_tx_er(i_tx_er), .o_tx_overrun(o_tx_overrun),
      .o_rx_clk(o_rx_clk), .o_rxd(o_rxd), .o_rx_dv(o_rx_dv), .o_rx_er(o_rx_er),
      .o_crs(o_crs), .o_col(o_col), .o_line_tx_valid(o_line_tx_valid),
      .i_line_tx_ready(i_line_tx_ready), .o_line_tx_nibble(o_line_tx_nibble),
      .o_line_tx_halt(o_line_tx_halt), .o_line_tx_active(o_line_tx_active),
      .o_line_speed_100(o_line_speed_100), .i_line_rx_carrier(i_line_rx_carrier),
      .i_line_rx_valid(i_line_rx_valid), .i_line_rx_nibble(i_line_rx_nibble),
      .i_line_rx_code_err(i_line_rx_code_err), .i_mdc(i_mdc), .i_mdio_in(i_mdio_in),
      .o_mdio_out(o_mdio_out), .o_mdio_oe(o_mdio_oe), .i_mgmt_drive(i_mgmt_drive),
      .i_mgmt_bit(i_mgmt_bit), .o_mgmt_sample(o_mgmt_sample), .o_mgmt_bit(o_mgmt_bit));
   pmi_mac_model i_pmi_mac_model (.i_clk(i_clk), .i_tx_clk(o_tx_clk), .i_stall(stall),
      .i_line_tx_valid(o_line_tx_valid), .i_line_tx_nibble(o_line_tx_nibble),
      .i_line_tx_halt(o_line_tx_halt), .o_line_tx_ready(i_line_tx_ready),
      .o_txd(i_txd), .o_tx_en(i_tx_en), .o_tx_er(i_tx_er));
   // Open-drain management line with a pull-up: low while either end pulls.
   assign i_mdio_in = !(o_mdio_oe || sme_pull);
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   // The run needs under a thousand cycles; past eight thousand it has hung.
   always @(posedge i_clk) begin
      cyc++;
      if (cyc >= 8000) begin
         fail_count++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask
   task automatic report_and_stop();
      if (fail_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic set_mode(input logic s, input logic f, input logic h);
      @(posedge i_clk);
      {i_speed_100, i_full_duplex, i_heartbeat_en} <= {s, f, h};
      repeat (60) @(posedge i_clk);
   endtask
   task automatic t_tx_halt();
      set_mode(1'b1, 1'b0, 1'b0);
      stall <= 1'b1;
      i_pmi_mac_model.send(1'b1, 4'h5, 1'b0);
      i_pmi_mac_model.send(1'b1, 4'ha, 1'b1);
      @(negedge i_clk);
      chk(o_crs, 1'b1, "crs in transmit");
      chk(o_line_tx_active, 1'b1, "tx active");
      chk(o_line_speed_100, 1'b1, "line speed");
      i_pmi_mac_model.send(1'b0, 4'h0, 1'b0);
      stall <= 1'b0;
      repeat (10) @(posedge i_clk);
      chk(8'(i_pmi_mac_model.got.size()), 8'h2, "count");
      chk(i_pmi_mac_model.got[1], 8'h1a, "halt");
      i_pmi_mac_model.got.delete();
      set_mode(1'b0, 1'b0, 1'b0);
      i_pmi_mac_model.send(1'b1, 4'h7, 1'b1);
      i_pmi_mac_model.send(1'b0, 4'h0, 1'b0);
      repeat (10) @(posedge i_clk);
      chk(o_line_speed_100, 1'b0, "line speed");
      chk(i_pmi_mac_model.got[0], 8'h07, "error ignored");
      i_pmi_mac_model.got.delete();
   endtask
   // Stalled encoder: the buffer fills, drops the surplus and flags it.
   task automatic t_overrun();
      set_mode(1'b1, 1'b0, 1'b0);
      stall <= 1'b1;
      for (int k = 1; k <= 5; k++) begin
         i_pmi_mac_model.send(1'b1, 4'(k), 1'b0);
      end
      @(negedge i_clk);
      chk(o_tx_overrun, 1'b1, "overrun set");
      i_pmi_mac_model.send(1'b0, 4'h0, 1'b0);
      stall <= 1'b0;
      repeat (10) @(posedge i_clk);
      chk(8'(i_pmi_mac_model.got.size()), 8'h3, "kept");
      chk(i_pmi_mac_model.got[2], 8'h03, "order");
      chk(o_tx_overrun, 1'b0, "overrun clear");
      i_pmi_mac_model.got.delete();
   endtask
   task automatic t_col_sqe();
      logic [7:0] n;
      n = 8'h0;
      set_mode(1'b0, 1'b0, 1'b1);
      i_line_rx_carrier <= 1'b1;
      i_pmi_mac_model.send(1'b1, 4'h3, 1'b0);
      repeat (18) @(posedge i_clk);
      @(negedge i_clk);
      chk(o_col, 1'b1, "collision");
      @(posedge i_clk);
      i_line_rx_carrier <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_pmi_mac_model.send(1'b0, 4'h0, 1'b0);
      repeat (100) begin
         @(negedge i_clk);
         n += (o_col === 1'b1) ? 8'h1 : 8'h0;
      end
      chk(n, SQE_CYC, "heartbeat length");
   endtask
   task automatic t_full();
      logic [7:0] n;
      n = 8'h0;
      set_mode(1'b0, 1'b1, 1'b1);
      i_pmi_mac_model.send(1'b1, 4'hc, 1'b0);
      repeat (18) @(posedge i_clk);
      @(negedge i_clk);
      chk(o_crs, 1'b0, "crs from transmit");
      @(posedge i_clk);
      i_line_rx_carrier <= 1'b1;
      i_pmi_mac_model.send(1'b0, 4'h0, 1'b0);
      repeat (80) begin
         @(negedge i_clk);
         n += (o_col === 1'b0) ? 8'h0 : 8'h1;
      end
      chk(n, 8'h0, "collision in full");
      chk(o_crs, 1'b1, "crs from receive");
      @(posedge i_clk);
      i_line_rx_carrier <= 1'b0;
   endtask
   task automatic rx_nib(input logic [NIB_W-1:0] d, input logic e, input logic er);
      @(posedge i_clk);
      {i_line_rx_valid, i_line_rx_nibble, i_line_rx_code_err} <= {1'b1, d, e};
      @(posedge i_clk);
      {i_line_rx_valid, i_line_rx_nibble} <= {1'b0, ~d};
      for (int k = 0; k < 40 && o_rx_dv !== 1'b1; k++) begin
         @(negedge i_clk);
      end
      chk(o_rx_dv, 1'b1, "rx valid");
      chk(o_rxd, 8'(d), "rx nibble");
      chk(o_rx_er, er, "rx error");
   endtask
   task automatic t_rx();
      set_mode(1'b1, 1'b0, 1'b0);
      rx_nib(4'h9, 1'b1, 1'b1);
      set_mode(1'b0, 1'b0, 1'b0);
      rx_nib(4'h6, 1'b1, 1'b0);
   endtask
   task automatic t_mdio();
      @(posedge i_clk);
      {i_mgmt_drive, i_mgmt_bit} <= 2'h2;
      repeat (2) @(posedge i_clk);
      chk(i_mdio_in, 1'b0, "device pulls low");
      {i_mgmt_drive, i_mgmt_bit} <= 2'h3;
      repeat (2) @(posedge i_clk);
      chk(i_mdio_in, 1'b1, "line released");
      {i_mgmt_drive, sme_pull, i_mdc} <= 3'h3;
      for (int k = 0; k < 10 && o_mgmt_sample !== 1'b1; k++) begin
         @(negedge i_clk);
      end
      chk(o_mgmt_sample, 1'b1, "sample pulse");
      chk(o_mgmt_bit, 1'b0, "bit captured");
      @(posedge i_clk);
      {sme_pull, i_mdc} <= 2'h0;
   endtask
   initial begin
      {i_rst_n, i_speed_100, i_full_duplex, i_heartbeat_en, stall, sme_pull} = 6'h0;
      {i_line_rx_carrier, i_line_rx_valid, i_line_rx_nibble, i_line_rx_code_err} = 7'h0;
      {i_mdc, i_mgmt_drive, i_mgmt_bit} = 3'h0;
      repeat (5) @(posedge i_clk);
      i_rst_n <= 1'b1;
      t_tx_halt();
      t_overrun();
      t_col_sqe();
      t_full();
      t_rx();
      t_mdio();
      report_and_stop();
   end
endmodule
`default_nettype wire
